/* rtl/rdc_core.sv */
// Per-channel register bank with converter update control and calibration
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Reserved register reads return zero, always the same for a given state.
// - Writes to reserved bits or locations change nothing.
// - Channel-1-only write where channel 1 lacks the control is discarded.
// - Multichannel write loads channel 0, drops channel 1 part where absent.
// - Multichannel write also loads channel 1 wherever channel 1 has it.
// - Writing one to load strobe copies all buffered levels of the selected channels to converters together.
// - Load strobe acts only in a write that also sets the mode bit to deferred; a write with mode bit zero ignores it.
// - Load strobe self clears; it always reads back zero.
// - Deferred mode buffers converter writes until a parallel load.
// - One load may update one channel or both channels together.
// - With calibration on, converter writes are corrected by gain and offset.
// - With calibration off, written data reaches converters unchanged.
// - Mode bit zero is immediate, the default; writes update directly.
// - Calibrated write multiplies by gain then adds offset.
// - Calibration enable lives only in channel 0 and governs the device.
module rdc_core #(
  parameter int NUM_DAC = rdc_pkg::NUM_DAC_DEF
) (
  input  wire logic                            core_clk,
  input  wire logic                            rst_b,
  input  wire logic                            wr_stb,
  input  wire logic                            rd_stb,
  input  wire logic [1:0]                      ch_sel,
  input  wire logic [rdc_pkg::ADDR_W-1:0]      addr,
  input  wire logic [rdc_pkg::DATA_W-1:0]      wdata,
  output logic      [rdc_pkg::DATA_W-1:0]      rdata_q,
  output logic      [2*NUM_DAC*16-1:0]         dac_level_q,
  output logic      [1:0]                      load_done_q,
  output logic      [1:0]                      defer_mode_q,
  output logic                                 cal_on_q
);
  import rdc_pkg::*;

  logic [15:0]        buf_q [2][NUM_DAC];
  logic [15:0]        buf_d [2][NUM_DAC];
  logic [15:0]        m_q   [2][NUM_DAC];
  logic [15:0]        m_d   [2][NUM_DAC];
  logic [15:0]        c_q   [2][NUM_DAC];
  logic [15:0]        c_d   [2][NUM_DAC];
  logic [2*NUM_DAC*16-1:0] dac_level_d;
  logic [15:0]        rdata_d;
  logic [1:0]         load_done_d;
  logic [1:0]         defer_mode_d;
  logic               cal_on_d;

  // Gain then offset; offset code 0x8000 means no shift
  function automatic logic [15:0] rdc_corr(input logic [15:0] x,
                                           input logic [15:0] m,
                                           input logic [15:0] c);
    logic [31:0]        p;
    logic signed [17:0] s;
    p = x * m;
    s = $signed({2'b00, p[31:16]}) + $signed({2'b00, c}) - C_ZERO;
    if (s < 0) begin
      return 16'h0000;
    end else if (s > SAT_MAX) begin
      return 16'hffff;
    end else begin
      return s[15:0];
    end
  endfunction

  always_comb begin
    logic       wr_ch;
    logic       rd_ch;
    logic [15:0] val;
    wr_ch        = 1'b0;
    rd_ch        = 1'b0;
    val          = 16'h0000;
    buf_d        = buf_q;
    m_d          = m_q;
    c_d          = c_q;
    dac_level_d  = dac_level_q;
    load_done_d  = 2'b00;
    defer_mode_d = defer_mode_q;
    cal_on_d     = cal_on_q;
    rdata_d      = rdata_q;
    // Each selected channel handled alike; absent channel-1 fields skipped
    for (int ch = 0; ch < 2; ch++) begin
      wr_ch = wr_stb && ch_sel[ch];
      if (wr_ch && addr == CTRL_ADDR) begin
        defer_mode_d[ch] = wdata[MODE_BIT];
        if (ch == CH0) begin
          cal_on_d = wdata[CAL_BIT];
        end
        // Strobe is never stored, so it reads back zero
        if (wdata[LOAD_BIT] && wdata[MODE_BIT]) begin
          load_done_d[ch] = 1'b1;
          for (int i = 0; i < NUM_DAC; i++) begin
            dac_level_d[(ch*NUM_DAC+i)*16 +: 16] = buf_q[ch][i];
          end
        end
      end
      for (int i = 0; i < NUM_DAC; i++) begin
        if (wr_ch && addr == ADDR_W'(DAC_BASE + i)) begin
          val = cal_on_q ? rdc_corr(wdata, m_q[ch][i], c_q[ch][i]) : wdata;
          buf_d[ch][i] = val;
          if (!defer_mode_q[ch]) begin
            dac_level_d[(ch*NUM_DAC+i)*16 +: 16] = val;
          end
        end
        if (wr_ch && addr == ADDR_W'(M_BASE + i)) begin
          m_d[ch][i] = wdata;
        end
        if (wr_ch && addr == ADDR_W'(C_BASE + i)) begin
          c_d[ch][i] = wdata;
        end
      end
    end
    // Read: channel 0 wins when both selected; unmapped reads as zero
    if (rd_stb) begin
      rd_ch   = !ch_sel[CH0];
      rdata_d = 16'h0000;
      if (addr == CTRL_ADDR) begin
        rdata_d[MODE_BIT] = defer_mode_q[rd_ch];
        rdata_d[CAL_BIT]  = rd_ch ? 1'b0 : cal_on_q;
      end
      for (int i = 0; i < NUM_DAC; i++) begin
        if (addr == ADDR_W'(DAC_BASE + i)) begin
          rdata_d = buf_q[rd_ch][i];
        end
        if (addr == ADDR_W'(M_BASE + i)) begin
          rdata_d = m_q[rd_ch][i];
        end
        if (addr == ADDR_W'(C_BASE + i)) begin
          rdata_d = c_q[rd_ch][i];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int ch = 0; ch < 2; ch++) begin
        for (int i = 0; i < NUM_DAC; i++) begin
          buf_q[ch][i] <= DAC_RST;
          m_q[ch][i]   <= M_RST;
          c_q[ch][i]   <= C_RST;
        end
      end
      dac_level_q  <= '0;
      rdata_q      <= 16'h0000;
      load_done_q  <= 2'b00;
      defer_mode_q <= 2'b00;
      cal_on_q     <= 1'b0;
    end else begin
      buf_q        <= buf_d;
      m_q          <= m_d;
      c_q          <= c_d;
      dac_level_q  <= dac_level_d;
      rdata_q      <= rdata_d;
      load_done_q  <= load_done_d;
      defer_mode_q <= defer_mode_d;
      cal_on_q     <= cal_on_d;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  strobe_reads_zero_a: assert property (
    rd_stb && addr == CTRL_ADDR |=> rdata_q[LOAD_BIT] == 1'b0)
    else $error("load strobe read back as one");
  imm_update_a: assert property (
    wr_stb && ch_sel == 2'b01 && addr == DAC_BASE && !defer_mode_q[0] && !cal_on_q
    |=> dac_level_q[15:0] == $past(wdata))
    else $error("immediate uncorrected write not applied");
  defer_hold_a: assert property (
    wr_stb && ch_sel == 2'b01 && addr == DAC_BASE && defer_mode_q[0]
    |=> $stable(dac_level_q) ##1 1'b1)
    else $error("deferred write reached converter");
  par_load_a: assert property (
    wr_stb && ch_sel == 2'b01 && addr == CTRL_ADDR && wdata[LOAD_BIT] && wdata[MODE_BIT]
    |=> load_done_q == 2'b01 && dac_level_q[15:0] == $past(buf_q[0][0]))
    else $error("parallel load did not copy buffer");
  imm_no_load_a: assert property (
    wr_stb && addr == CTRL_ADDR && wdata[LOAD_BIT] && !wdata[MODE_BIT]
    |=> load_done_q == 2'b00 && $stable(dac_level_q))
    else $error("load acted in immediate mode");
  ch1_cal_ignored_a: assert property (
    wr_stb && ch_sel == 2'b10 && addr == CTRL_ADDR |=> $stable(cal_on_q))
    else $error("channel 1 write changed calibration enable");
  multi_ctrl_a: assert property (
    wr_stb && ch_sel == 2'b11 && addr == CTRL_ADDR
    |=> defer_mode_q == {2{$past(wdata[MODE_BIT])}} && cal_on_q == $past(wdata[CAL_BIT]))
    else $error("multichannel control write mishandled");
  rsvd_write_a: assert property (
    wr_stb && addr == RSVD_PROBE
    |=> $stable(dac_level_q) && $stable(defer_mode_q) && $stable(cal_on_q))
    else $error("reserved write changed state");
  rsvd_read_a: assert property (
    rd_stb && addr == RSVD_PROBE |=> rdata_q == 16'h0000)
    else $error("reserved read not zero");
  cal_apply_a: assert property (
    wr_stb && ch_sel == 2'b01 && addr == DAC_BASE && !defer_mode_q[0] && cal_on_q
    |=> dac_level_q[15:0] == rdc_corr($past(wdata), $past(m_q[0][0]), $past(c_q[0][0])))
    else $error("calibrated value wrong");
  load_cause_a: assert property (
    !(wr_stb && ch_sel[CH0] && addr == CTRL_ADDR && wdata[LOAD_BIT] && wdata[MODE_BIT])
    |=> !load_done_q[CH0])
    else $error("channel 0 load pulse without a load write");
  multi_load_a: assert property (
    wr_stb && ch_sel == 2'b11 && addr == CTRL_ADDR && wdata[LOAD_BIT] && wdata[MODE_BIT]
    |=> load_done_q == 2'b11)
    else $error("multichannel load missed a channel");
  ch1_plain_a: assert property (
    wr_stb && ch_sel == 2'b10 && addr == DAC_BASE && !defer_mode_q[CH1] && !cal_on_q
    |=> dac_level_q[NUM_DAC*16 +: 16] == $past(wdata))
    else $error("channel 1 uncorrected write not applied");
  ch1_no_cal_a: assert property (
    rd_stb && ch_sel == 2'b10 && addr == CTRL_ADDR
    |=> !rdata_q[CAL_BIT])
    else $error("channel 1 control read shows calibration enable");
  mode_capture_a: assert property (
    wr_stb && ch_sel[CH0] && addr == CTRL_ADDR
    |=> defer_mode_q[CH0] == $past(wdata[MODE_BIT]))
    else $error("channel 0 mode bit not captured");
endmodule
`default_nettype wire

/* rtl/rdc_pkg.sv */
// Constants for the converter update control block
package rdc_pkg;
  localparam int              ADDR_W      = 7;
  localparam int              DATA_W      = 16;
  localparam int              NUM_DAC_DEF = 8;
  localparam logic [6:0]      CTRL_ADDR   = 7'h11;
  localparam logic [6:0]      DAC_BASE    = 7'h01;
  localparam logic [6:0]      M_BASE      = 7'h21;
  localparam logic [6:0]      C_BASE      = 7'h31;
  localparam logic [6:0]      RSVD_PROBE  = 7'h7f;
  localparam int              CAL_BIT     = 0;
  localparam int              MODE_BIT    = 1;
  localparam int              LOAD_BIT    = 2;
  localparam int              CH0         = 0;
  localparam int              CH1         = 1;
  localparam logic [15:0]     M_RST       = 16'hffff;
  localparam logic [15:0]     C_RST       = 16'h8000;
  localparam logic [15:0]     DAC_RST     = 16'h0000;
  localparam logic signed [17:0] C_ZERO   = 18'sh08000;
  localparam logic signed [17:0] SAT_MAX  = 18'sh0ffff;
endpackage

/* sim/rdc_host.sv */
// Host model driving the register port of the update control block
`timescale 1ns/10ps
`default_nettype none
module rdc_host (
  input  wire logic                       core_clk,
  output logic                            wr_stb,
  output logic                            rd_stb,
  output logic [1:0]                      ch_sel,
  output logic [rdc_pkg::ADDR_W-1:0]      addr,
  output logic [rdc_pkg::DATA_W-1:0]      wdata
);
  import rdc_pkg::*;
  initial begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    ch_sel = 2'b00;
    addr   = 7'h00;
    wdata  = 16'h0000;
  end
  // One transfer; afterwards strobes drop low and address and data show inverted values
  task automatic xfer(input logic wr, input logic [1:0] ch, input logic [6:0] a,
                      input logic [15:0] d);
    @(negedge core_clk);
    wr_stb = wr;
    rd_stb = ~wr;
    ch_sel = ch;
    addr   = a;
    wdata  = d;
    @(negedge core_clk);
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr   = ~a;
    wdata  = ~d;
  endtask
endmodule
`default_nettype wire

/* sim/dac_update_control_tb_top.sv */
// Self-checking bench for the converter update control block
`timescale 1ns/10ps
`default_nettype none
module dac_update_control_tb_top;
  import rdc_pkg::*;
  localparam int ND = 4;
  logic              core_clk;
  logic              rst_b;
  logic              wr_stb;
  logic              rd_stb;
  logic [1:0]        ch_sel;
  logic [6:0]        addr;
  logic [15:0]       wdata;
  logic [15:0]       rdata_q;
  logic [2*ND*16-1:0] dac_level_q;
  logic [1:0]        load_done_q;
  logic [1:0]        defer_mode_q;
  logic              cal_on_q;
  logic [15:0]       lv [0:2*ND-1];
  logic [15:0]       d;
  int                fail_count = 0;
  int                cmp_count = 0;
  int                seed = 32'he525cb31;
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  rdc_host h (.core_clk(core_clk), .wr_stb(wr_stb), .rd_stb(rd_stb), .ch_sel(ch_sel),
              .addr(addr), .wdata(wdata));
  rdc_core #(.NUM_DAC(ND)) DUT (.core_clk(core_clk), .rst_b(rst_b), .wr_stb(wr_stb),
    .rd_stb(rd_stb), .ch_sel(ch_sel), .addr(addr), .wdata(wdata), .rdata_q(rdata_q),
    .dac_level_q(dac_level_q), .load_done_q(load_done_q), .defer_mode_q(defer_mode_q),
    .cal_on_q(cal_on_q));
  function automatic logic [15:0] cal(input logic [15:0] x, input logic [15:0] m,
                                      input logic [15:0] c);
    int s;
    s = int'((32'(x) * 32'(m)) >> 16) + int'(c) - 32'sh8000;
    if (s < 0) begin
      return 16'h0000;
    end
    if (s > 32'sh0ffff) begin
      return 16'hffff;
    end
    return 16'(s);
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic lvl_all(input string nm);
    for (int i = 0; i < 2*ND; i++) begin
      chk(nm, lv[i], dac_level_q[i*16 +: 16]);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
  initial begin
    rst_b = 1'b0;
    for (int i = 0; i < 2*ND; i++) lv[i] = DAC_RST;
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    rst_b = 1'b1;
    h.xfer(1'b0, 2'b01, M_BASE, 16'h0000);
    chk("m_reset", M_RST, rdata_q);
    h.xfer(1'b0, 2'b10, C_BASE + 7'h01, 16'h0000);
    chk("c_reset", C_RST, rdata_q);
    h.xfer(1'b1, 2'b11, RSVD_PROBE, 16'hffff);
    h.xfer(1'b1, 2'b10, CTRL_ADDR, 16'h0001);
    chk("cal_ch1_only", 16'h0000, 16'(cal_on_q));
    h.xfer(1'b1, 2'b01, CTRL_ADDR, 16'hfff8);
    h.xfer(1'b0, 2'b01, CTRL_ADDR, 16'h0000);
    chk("ctrl_rsvd_bits", 16'h0000, rdata_q);
    chk("mode_default", 16'h0000, 16'(defer_mode_q));
    lvl_all("rsvd_write");
    repeat (2) begin
      h.xfer(1'b0, 2'b11, RSVD_PROBE, 16'h0000);
      chk("rsvd_read", 16'h0000, rdata_q);
    end
    for (int i = 0; i < 2*ND; i++) begin
      d = 16'($random(seed));
      lv[i] = d;
      h.xfer(1'b1, (i < ND) ? 2'b01 : 2'b10, DAC_BASE + 7'(i % ND), d);
      chk("imm_level", d, dac_level_q[i*16 +: 16]);
    end
    h.xfer(1'b1, 2'b11, M_BASE + 7'h02, 16'h8000);
    h.xfer(1'b1, 2'b11, C_BASE + 7'h02, 16'h8010);
    h.xfer(1'b1, 2'b11, CTRL_ADDR, 16'h0001);
    chk("cal_multi", 16'h0001, 16'(cal_on_q));
    h.xfer(1'b0, 2'b10, CTRL_ADDR, 16'h0000);
    chk("cal_ch1_read", 16'h0000, rdata_q);
    for (int c = 0; c < 2; c++) begin
      d = 16'($random(seed));
      lv[c*ND+2] = cal(d, 16'h8000, 16'h8010);
      h.xfer(1'b1, c ? 2'b10 : 2'b01, DAC_BASE + 7'h02, d);
      chk("cal_level", lv[c*ND+2], dac_level_q[(c*ND+2)*16 +: 16]);
    end
    lv[0] = cal(16'hffff, M_RST, C_RST);
    h.xfer(1'b1, 2'b01, DAC_BASE, 16'hffff);
    chk("cal_unity", lv[0], dac_level_q[15:0]);
    h.xfer(1'b1, 2'b10, C_BASE + 7'h01, 16'h0000);
    lv[ND+1] = cal(16'h0100, M_RST, 16'h0000);
    h.xfer(1'b1, 2'b10, DAC_BASE + 7'h01, 16'h0100);
    chk("cal_sat_low", lv[ND+1], dac_level_q[(ND+1)*16 +: 16]);
    h.xfer(1'b1, 2'b01, C_BASE + 7'h01, 16'hffff);
    lv[1] = cal(16'hffff, M_RST, 16'hffff);
    h.xfer(1'b1, 2'b01, DAC_BASE + 7'h01, 16'hffff);
    chk("cal_sat_high", lv[1], dac_level_q[31:16]);
    h.xfer(1'b1, 2'b11, CTRL_ADDR, 16'h0002);
    chk("defer_both", 16'h0003, 16'(defer_mode_q));
    h.xfer(1'b1, 2'b01, DAC_BASE, 16'h1234);
    h.xfer(1'b1, 2'b10, DAC_BASE + 7'h03, 16'hbeef);
    lvl_all("held");
    h.xfer(1'b1, 2'b11, CTRL_ADDR, 16'h0006);
    chk("load_pulse", 16'h0003, 16'(load_done_q));
    lv[0] = 16'h1234;
    lv[ND+3] = 16'hbeef;
    lvl_all("loaded");
    h.xfer(1'b1, 2'b01, DAC_BASE + 7'h01, 16'h5a5a);
    h.xfer(1'b1, 2'b01, CTRL_ADDR, 16'h0006);
    chk("load_ch0", 16'h0001, 16'(load_done_q));
    lv[1] = 16'h5a5a;
    lvl_all("loaded_ch0");
    h.xfer(1'b1, 2'b01, DAC_BASE + 7'h02, 16'ha5a5);
    h.xfer(1'b0, 2'b01, CTRL_ADDR, 16'h0000);
    chk("strobe_clear", 16'h0002, rdata_q);
    h.xfer(1'b1, 2'b01, CTRL_ADDR, 16'h0004);
    chk("imm_no_load", 16'h0000, 16'(load_done_q));
    lvl_all("imm_no_load_lvl");
    // Reset again in mid run
    @(negedge core_clk);
    rst_b = 1'b0;
    @(negedge core_clk);
    for (int i = 0; i < 2*ND; i++) begin
      lv[i] = DAC_RST;
    end
    lvl_all("reset_level");
    chk("reset_mode", 16'h0000, 16'(defer_mode_q));
    chk("reset_cal", 16'h0000, 16'(cal_on_q));
    rst_b = 1'b1;
    h.xfer(1'b0, 2'b10, C_BASE + 7'h01, 16'h0000);
    chk("c_after_reset", C_RST, rdata_q);
    end_sim();
  end
endmodule
`default_nettype wire
